// file: rtl/tuc_timer_irq.sv
// Contract
// - Counter wrap from zero sets underflow flag
// - Writing zero to flag clears it
// - Request only while flag and enable set
// - Underflow request per channel, capture on two
// - Rank ch0, ch1, ch2 underflow, then capture
// - Accepted interrupt loads its source code
// - Read during decrement returns earlier value
// - Underflow reloads counter and keeps counting
// - Counting starts when run bit set
// - Underflow request also rises when enable is set after the flag
//
// The Wishbone register port and the placing of the registers were decided locally.
module tuc_timer_irq
	import tuc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic             capture_i,
	input  wire logic             irq_accept_i,
	output logic                  underflow_irq_ch0_o,
	output logic                  underflow_irq_ch1_o,
	output logic                  underflow_irq_ch2_o,
	output logic                  capture_irq_ch2_o,
	output logic      [EXC_W-1:0] exception_code_o,
	output logic                  irq_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] neu,
	                                      input logic [3:0]  sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = neu[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [ADR_W-1:0] ch_adr(input logic [ADR_W-1:0] base,
	                                            input int ch);
		return base + CH_STRIDE * ch[ADR_W-1:0];
	endfunction

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	tuc_chan_if #(.W(CNT_W)) ch_bus [NUM_CH] ();

	logic [NUM_CH-1:0] run;
	logic [NUM_CH-1:0] wrap;
	logic [CNT_W-1:0]  cnt_v [NUM_CH];
	logic [CNT_W-1:0]  rld_v [NUM_CH];
	logic              wr;
	logic              rd;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic ld_c;
		logic ld_r;
		// Writes are not synchronised with counting
		assign ld_c = wr && wb_adr_i == ch_adr(ADR_CNT0, g);
		assign ld_r = wr && wb_adr_i == ch_adr(ADR_RLD0, g);
		assign ch_bus[g].run      = run[g];
		assign ch_bus[g].load_cnt = ld_c;
		assign ch_bus[g].load_rld = ld_r;
		assign ch_bus[g].wdata    = ld_c
			? merge(ch_bus[g].count, wb_dat_i, wb_sel_i)
			: merge(ch_bus[g].reload, wb_dat_i, wb_sel_i);
		assign wrap[g]  = ch_bus[g].wrap;
		assign cnt_v[g] = ch_bus[g].count;
		assign rld_v[g] = ch_bus[g].reload;

		tuc_channel u_ch (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.bus   (ch_bus[g].chan)
		);
	end

	// ------------------------------------------------------------
	// Capture pin synchroniser
	// ------------------------------------------------------------
	logic [2:0] cap_sync;
	logic       cap_edge;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_sync <= '0;
		end else begin
			cap_sync <= {cap_sync[1:0], capture_i};
		end
	end

	// Stage 0 is read only by stage 1
	assign cap_edge = cap_sync[1] && !cap_sync[2];

	// ------------------------------------------------------------
	// Control, flags and bus
	// ------------------------------------------------------------
	logic [NUM_CH-1:0] uie, next_uie, unf, next_unf, next_run;
	logic              cie, next_cie, capf, next_capf;
	logic [CNT_W-1:0]  cap_reg, next_cap_reg;
	logic [SRC_N-1:0]  ist, next_ist, imsk, next_imsk;
	logic [SRC_N-1:0]  req, next_req, events;
	logic [EXC_W-1:0]  exc, next_exc, rank_code;
	logic              rank_any, next_ack, next_irq;
	logic [31:0]       next_dat;

	assign events = {cap_edge, wrap};

	always_comb begin
		next_run     = run;
		next_uie     = uie;
		next_cie     = cie;
		next_imsk    = imsk;
		next_ist     = ist;
		next_cap_reg = cap_edge ? cnt_v[2] : cap_reg;
		next_unf     = unf;
		next_capf    = capf;
		next_dat     = '0;
		if (wr && wb_sel_i[0]) begin
			if (wb_adr_i == ADR_RUN) begin
				next_run = wb_dat_i[NUM_CH-1:0];
			end
			if (wb_adr_i == ADR_IMSK) begin
				next_imsk = wb_dat_i[SRC_N-1:0];
			end
			if (wb_adr_i == ADR_IST) begin
				next_ist = ist & ~wb_dat_i[SRC_N-1:0];
			end
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (wr && wb_adr_i == ch_adr(ADR_CTL0, i)) begin
				if (wb_sel_i[0]) begin
					next_uie[i] = wb_dat_i[CTL_UIE_BIT];
					if (i == 2) begin
						next_cie = wb_dat_i[CTL_CIE_BIT];
					end
				end
				// Only a zero clears; a one is ignored
				if (wb_sel_i[1] && !wb_dat_i[CTL_UNF_BIT]) begin
					next_unf[i] = 1'b0;
				end
				if (i == 2 && wb_sel_i[1] && !wb_dat_i[CTL_CAP_BIT]) begin
					next_capf = 1'b0;
				end
			end
			if (wrap[i]) begin
				next_unf[i] = 1'b1;
			end
		end
		if (cap_edge) begin
			next_capf = 1'b1;
		end
		// Events win over a same-cycle clear
		next_ist = next_ist | events;
		next_irq = |(ist & imsk);
		next_req = {capf & cie, unf & uie};
		next_exc = (irq_accept_i && rank_any) ? rank_code : exc;
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		// Counter sampled before this edge's decrement
		if (rd) begin
			if (wb_adr_i == ADR_RUN) begin
				next_dat = 32'(run);
			end else if (wb_adr_i == ADR_EXC) begin
				next_dat = 32'(exc);
			end else if (wb_adr_i == ADR_IST) begin
				next_dat = 32'(ist);
			end else if (wb_adr_i == ADR_IMSK) begin
				next_dat = 32'(imsk);
			end else if (wb_adr_i == ADR_CAP2) begin
				next_dat = cap_reg;
			end
			for (int i = 0; i < NUM_CH; i++) begin
				if (wb_adr_i == ch_adr(ADR_CTL0, i)) begin
					next_dat[CTL_UIE_BIT] = uie[i];
					next_dat[CTL_UNF_BIT] = unf[i];
					if (i == 2) begin
						next_dat[CTL_CIE_BIT] = cie;
						next_dat[CTL_CAP_BIT] = capf;
					end
				end
				if (wb_adr_i == ch_adr(ADR_RLD0, i)) begin
					next_dat = rld_v[i];
				end
				if (wb_adr_i == ch_adr(ADR_CNT0, i)) begin
					next_dat = cnt_v[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run      <= '0;
			uie      <= '0;
			cie      <= 1'b0;
			unf      <= '0;
			capf     <= 1'b0;
			cap_reg  <= '0;
			ist      <= '0;
			imsk     <= '0;
			req      <= '0;
			exc      <= EXC_NONE;
			irq_o    <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			run      <= next_run;
			uie      <= next_uie;
			cie      <= next_cie;
			unf      <= next_unf;
			capf     <= next_capf;
			cap_reg  <= next_cap_reg;
			ist      <= next_ist;
			imsk     <= next_imsk;
			req      <= next_req;
			exc      <= next_exc;
			irq_o    <= next_irq;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	tuc_rank u_rank (
		.req_i  (req),
		.code_o (rank_code),
		.any_o  (rank_any)
	);

	assign underflow_irq_ch0_o = req[0];
	assign underflow_irq_ch1_o = req[1];
	assign underflow_irq_ch2_o = req[2];
	assign capture_irq_ch2_o   = req[3];
	assign exception_code_o    = exc;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic ctl0_clr;
	assign ctl0_clr = wr && wb_adr_i == ADR_CTL0 && wb_sel_i[1]
		&& !wb_dat_i[CTL_UNF_BIT];

	a_unf_on_wrap: assert property (wrap[1] |=> unf[1])
		else $error("underflow flag not set on wrap");
	a_unf_clear: assert property (ctl0_clr && !wrap[0] |=> !unf[0])
		else $error("underflow flag not cleared by zero write");
	a_req_cause: assert property (underflow_irq_ch1_o |->
		$past(unf[1]) && $past(uie[1]))
		else $error("request without flag and enable");
	a_cap_req: assert property (cap_edge && cie |-> ##2
		capture_irq_ch2_o)
		else $error("capture request missing");
	a_rank_order: assert property (irq_accept_i && req[0] |=>
		exc == EXC_UNF0)
		else $error("channel 0 not ranked first");
	a_exc_hold: assert property (!irq_accept_i |=> $stable(exc))
		else $error("source code changed without accept");
	a_read_pre: assert property (rd && wb_adr_i == ADR_CNT0 |=>
		wb_ack_o && wb_dat_o == $past(cnt_v[0]))
		else $error("counter read not pre-decrement");
	a_reload: assert property (wrap[0] |=> cnt_v[0] == $past(rld_v[0])
		&& !wrap[0] || rld_v[0] == '0)
		else $error("no reload after underflow");
	a_halt: assert property (!run[2] && !ch_bus[2].load_cnt |=>
		$stable(cnt_v[2]))
		else $error("counter moved while halted");
	a_set_wins: assert property (ctl0_clr && wrap[0] |=> unf[0])
		else $error("clear beat underflow set");
	a_req_drop: assert property (!unf[2] || !uie[2] |=>
		!underflow_irq_ch2_o)
		else $error("request stayed after flag or enable fell");

	a_req_rise: assert property (unf[0] && uie[0] |=>
		underflow_irq_ch0_o)
		else $error("enabled underflow raised no request");

	c_wrap:    cover property (wrap[0] ##1 underflow_irq_ch0_o);
	c_accept:  cover property (irq_accept_i && req[3] && !req[0]);
	c_capture: cover property (cap_edge ##1 capf);
	c_lane:    cover property (wr && wb_sel_i == 4'h1);

endmodule

// file: rtl/tuc_pkg.sv
package tuc_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_CH = 3;
	localparam int CNT_W  = 32;
	localparam int ADR_W  = 8;
	localparam int EXC_W  = 12;
	localparam int SRC_N  = 4;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADR_W-1:0] ADR_RUN   = 8'h00;
	localparam logic [ADR_W-1:0] ADR_EXC   = 8'h04;
	localparam logic [ADR_W-1:0] ADR_IST   = 8'h08;
	localparam logic [ADR_W-1:0] ADR_IMSK  = 8'h0C;
	localparam logic [ADR_W-1:0] ADR_CTL0  = 8'h10;
	localparam logic [ADR_W-1:0] ADR_RLD0  = 8'h14;
	localparam logic [ADR_W-1:0] ADR_CNT0  = 8'h18;
	localparam logic [ADR_W-1:0] CH_STRIDE = 8'h10;
	localparam logic [ADR_W-1:0] ADR_CAP2  = 8'h40;

	// ------------------------------------------------------------
	// Field positions in the channel control register
	// ------------------------------------------------------------
	localparam int CTL_UIE_BIT = 0;
	localparam int CTL_CIE_BIT = 1;
	localparam int CTL_UNF_BIT = 8;
	localparam int CTL_CAP_BIT = 9;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] CNT_RST = 32'hFFFF_FFFF;
	localparam logic [CNT_W-1:0] RLD_RST = 32'hFFFF_FFFF;

	// ------------------------------------------------------------
	// Source codes, arbitrary values
	// ------------------------------------------------------------
	localparam logic [EXC_W-1:0] EXC_NONE = 12'h000;
	localparam logic [EXC_W-1:0] EXC_UNF0 = 12'h400;
	localparam logic [EXC_W-1:0] EXC_UNF1 = 12'h420;
	localparam logic [EXC_W-1:0] EXC_UNF2 = 12'h440;
	localparam logic [EXC_W-1:0] EXC_CAP2 = 12'h460;

endpackage

// file: rtl/tuc_chan_if.sv
interface tuc_chan_if #(parameter int W = 32);
	logic         run;
	logic         load_cnt;
	logic         load_rld;
	logic [W-1:0] wdata;
	logic [W-1:0] count;
	logic [W-1:0] reload;
	logic         wrap;

	modport ctrl (output run, load_cnt, load_rld, wdata,
	              input  count, reload, wrap);
	modport chan (input  run, load_cnt, load_rld, wdata,
	              output count, reload, wrap);
endinterface

// file: rtl/tuc_channel.sv
module tuc_channel
	import tuc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	tuc_chan_if.chan  bus
);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] reload;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] next_reload;

	// ------------------------------------------------------------
	// Down counter with auto reload
	// ------------------------------------------------------------
	// Wrap only while running and not being written
	assign bus.wrap   = bus.run && !bus.load_cnt && count == '0;
	assign bus.count  = count;
	assign bus.reload = reload;

	always_comb begin
		next_reload = bus.load_rld ? bus.wdata : reload;
		next_count  = count;
		if (bus.load_cnt) begin
			next_count = bus.wdata;
		end else if (bus.wrap) begin
			next_count = reload;
		end else if (bus.run) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count  <= CNT_RST;
			reload <= RLD_RST;
		end else begin
			count  <= next_count;
			reload <= next_reload;
		end
	end

endmodule

// file: rtl/tuc_rank.sv
module tuc_rank
	import tuc_pkg::*;
(
	input  wire logic [SRC_N-1:0] req_i,
	output logic      [EXC_W-1:0] code_o,
	output logic                  any_o
);

	// ------------------------------------------------------------
	// Fixed ranking, lowest index wins
	// ------------------------------------------------------------
	function automatic logic [EXC_W-1:0] pick(input logic [SRC_N-1:0] r);
		if (r[0]) begin
			return EXC_UNF0;
		end else if (r[1]) begin
			return EXC_UNF1;
		end else if (r[2]) begin
			return EXC_UNF2;
		end else if (r[3]) begin
			return EXC_CAP2;
		end
		return EXC_NONE;
	endfunction

	assign code_o = pick(req_i);
	assign any_o  = |req_i;

endmodule

// file: sim/tuc_intc_model.sv
module tuc_intc_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       en_i,
	input  wire logic [3:0] req_i,
	output logic            accept_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] wait_n;

	initial accept_o = 1'b0;

	// ------------------------------------------------------------
	// Acceptance
	// ------------------------------------------------------------
	// Random pause once requests appear, then accept held while any request stays
	always @(posedge clk_i) begin
		if (rst_i || !en_i || req_i == 4'h0) begin
			accept_o <= 1'b0;
			wait_n   <= 2'($urandom);
		end else if (wait_n != 2'h0) begin
			accept_o <= 1'b0;
			wait_n   <= wait_n - 2'h1;
		end else begin
			accept_o <= 1'b1;
		end
	end
endmodule

// file: sim/tuc_timer_irq_bench.sv
module tuc_timer_irq_bench;
	import tuc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             cyc = 1'b0;
	logic             stb = 1'b0;
	logic             we = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic [3:0]       sel = 4'h0;
	logic [31:0]      wd = '0;
	logic [31:0]      rd, v, w, r, c;
	logic             ack, acc, irq, cirq;
	logic             cap = 1'b0;
	logic             en = 1'b0;
	logic [3:0]       sm = 4'hF;
	logic [2:0]       uirq;
	logic [EXC_W-1:0] code;
	int               n_fail = 0;
	int               n_checks = 0;
	int               cyc_n = 0;
	int               stamp, s0;

	always #50 clk_i = ~clk_i;

	tuc_timer_irq dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .capture_i(cap),
		.irq_accept_i(acc), .underflow_irq_ch0_o(uirq[0]),
		.underflow_irq_ch1_o(uirq[1]), .underflow_irq_ch2_o(uirq[2]),
		.capture_irq_ch2_o(cirq), .exception_code_o(code), .irq_o(irq));

	tuc_intc_model icm (.clk_i(clk_i), .rst_i(rst_i), .en_i(en),
		.req_i({cirq, uirq}), .accept_o(acc));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	// Classic cycle; caller must stand just after a rising edge
	task automatic bus(input logic wr_en, input logic [ADR_W-1:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= wr_en;
		adr <= a;
		sel <= sm;
		wd  <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && t < 50) begin
			@(posedge clk_i);
			t++;
		end
		if (t == 50)
			n_fail++;
		q = rd;
		stamp = cyc_n;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d, v);
	endtask

	task automatic rdc(input string nm, input logic [ADR_W-1:0] a,
			input logic [31:0] e);
		bus(1'b0, a, 32'h0, v);
		chk(nm, e, v);
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wait_req(input logic [2:0] m);
		int t;
		t = 0;
		while ((uirq & m) !== m && t < 200) begin
			@(posedge clk_i);
			t++;
		end
	endtask

	function automatic logic [ADR_W-1:0] ra(input int k, input int off);
		return ADR_W'(ADR_CTL0 + off + k * CH_STRIDE);
	endfunction

	function automatic logic [31:0] rank(input logic [3:0] q);
		if (q[0]) return {20'h0, EXC_UNF0};
		if (q[1]) return {20'h0, EXC_UNF1};
		if (q[2]) return {20'h0, EXC_UNF2};
		if (q[3]) return {20'h0, EXC_CAP2};
		return {20'h0, EXC_NONE};
	endfunction

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		void'($urandom(33947));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("outs", 32'h0, {27'h0, cirq, uirq, irq});
		chk("code", 32'h0, {20'h0, code});
		rdc("cnt0", ADR_CNT0, CNT_RST);
		rdc("ctl0", ADR_CTL0, 32'h0);
		wr(8'h1C, 32'h1234_5678);
		rdc("unmapped", 8'h1C, 32'h0);
		rdc("cnt0", ADR_CNT0, CNT_RST);
		$display("test reset done");

		for (int k = 0; k < NUM_CH; k++) begin
			r = 32'h40 + ($urandom % 32'h40);
			c = 2 + ($urandom % 8);
			wr(ADR_RUN, 32'h0);
			wr(ra(k, 4), r);
			wr(ra(k, 8), c);
			wr(ra(k, 0), 32'h0);
			wr(ADR_IMSK, 32'h1 << k);
			wr(ADR_RUN, 32'h1 << k);
			cycles(c + 4);
			rdc("flag", ra(k, 0), 32'h100);
			chk("req off", 32'h0, {31'h0, uirq[k]});
			chk("irq", 32'h1, {31'h0, irq});
			// Halt before touching control, writes are not synchronised
			wr(ADR_RUN, 32'h0);
			wr(ra(k, 0), 32'h101);
			chk("req on", 32'h1, {31'h0, uirq[k]});
			rdc("flag kept", ra(k, 0), 32'h101);
			bus(1'b0, ra(k, 8), 32'h0, v);
			chk("reloaded", 32'h1, {31'h0, v <= r});
			// Bus clock source, so a plain clearing write suffices
			wr(ra(k, 0), 32'h1);
			chk("req drop", 32'h0, {31'h0, uirq[k]});
			wr(ADR_IST, 32'h1 << k);
			chk("irq clr", 32'h0, {31'h0, irq});
			wr(ADR_RUN, 32'h1 << k);
			wait_req(3'h1 << k);
			chk("again", 32'h1, {31'h0, uirq[k]});
			wr(ADR_RUN, 32'h0);
			wr(ra(k, 0), 32'h0);
			wr(ADR_IST, 32'hF);
		end
		$display("test underflow done");

		wr(ADR_CNT0, 32'h0010_0000);
		wr(ADR_RUN, 32'h1);
		s0 = stamp;
		bus(1'b0, ADR_CNT0, 32'h0, v);
		// Count starts the edge after the run bit lands
		chk("cnt read", 32'(32'h0010_0000 - (stamp - s0 - 1)), v);
		wr(ADR_RUN, 32'h0);
		$display("test read sync done");

		for (int k = 0; k < NUM_CH; k++) begin
			wr(ra(k, 8), 32'h3);
			wr(ra(k, 0), 32'h1);
		end
		wr(ADR_RUN, 32'h7);
		wait_req(3'h7);
		wr(ADR_RUN, 32'h0);
		chk("reqs", 32'h7, {29'h0, uirq});
		// Flag lane left out, so the flag must survive the write
		sm = 4'h1;
		wr(ra(0, 0), 32'h1);
		sm = 4'hF;
		rdc("lane", ra(0, 0), 32'h101);
		en <= 1'b1;
		for (int k = 0; k < NUM_CH; k++) begin
			cycles(8);
			chk("code", rank(4'h7 & (4'hF << k)), {20'h0, code});
			wr(ra(k, 0), 32'h1);
		end
		wr(ra(2, 0), 32'h2);
		bus(1'b0, ra(2, 8), 32'h0, w);
		cap <= 1'b1;
		cycles(6);
		cap <= 1'b0;
		cycles(4);
		chk("cap req", 32'h1, {31'h0, cirq});
		chk("code", rank(4'h8), {20'h0, code});
		rdc("exc reg", ADR_EXC, rank(4'h8));
		rdc("cap val", ADR_CAP2, w);
		wr(ra(2, 0), 32'h2);
		chk("cap drop", 32'h0, {31'h0, cirq});
		$display("test ranking done");
		complete_run();
	end
endmodule
